/* File: core/dcsp_pkg.sv */
// Constants, status and command layout and register map of the dual-card serial control port
`default_nettype none
package dcsp_pkg;
   localparam int WORD_W = 16;
   localparam logic [15:0] CMD_RESET = 16'h0000;
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   // Command word fields
   localparam int CMD_B_VSEL_LO = 0;
   localparam int CMD_B_SELECT = 2;
   localparam int CMD_PULLUP_DIS = 3;
   localparam int CMD_A_VSEL_LO = 8;
   localparam int CMD_A_SELECT = 10;
   // Status word fields
   localparam int ST_B_ELEC = 4;
   localparam int ST_B_ATR = 5;
   localparam int ST_B_PRESENT = 7;
   localparam int ST_A_ELEC = 12;
   localparam int ST_A_ATR = 13;
   localparam int ST_A_PRESENT = 15;
   // Timing
   localparam int CLK_MHZ = 250;
   localparam int DEBOUNCE_MS = 35;
   localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CLK_MHZ * 1000;
   localparam int DEACT_MAX_US = 30;
   localparam int DEACT_MAX_CYC = DEACT_MAX_US * CLK_MHZ;
   localparam int DEB_CNT_W = 24;
   // AHB-Lite register map, byte addresses
   localparam int ADDR_W = 4;
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_COMMAND = 4'h4;
   localparam logic [3:0] REG_CONFIG = 4'h8;
   localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
   localparam int CFG_DETECT_HIGH = 0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;
endpackage : dcsp_pkg
`default_nettype wire

/* File: core/dcsp_sync.sv */
// Two-flop synchroniser for a group of pins from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module dcsp_sync #(
   parameter int W = 1
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] sync_nxt;

   // First stage feeds only the second stage
   always_comb
   begin
      meta_nxt = async_in;
      sync_nxt = meta_r;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         meta_r <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_r <= meta_nxt;
         sync_out <= sync_nxt;
      end
   end
endmodule : dcsp_sync
`default_nettype wire

/* File: core/dcsp_top.sv */
// Dual-card serial control port with fault logic and AHB-Lite register window
`timescale 1ns/100ps
`default_nettype none
module dcsp_top #(
   parameter int unsigned DEBOUNCE_CYCLES = dcsp_pkg::DEBOUNCE_CYC
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic sclk_pin,
   input wire logic din_pin,
   input wire logic load_strobe_n,
   output logic dout_pin,
   input wire logic card_detect_input_a,
   input wire logic card_detect_input_b,
   input wire logic supply_low_monitor_n,
   input wire logic elec_fault_in_a,
   input wire logic elec_fault_in_b,
   input wire logic atr_timeout_in_a,
   input wire logic atr_timeout_in_b,
   input wire logic card_reset_a,
   input wire logic card_reset_b,
   output logic fault_n_o,
   output logic fault_n_oe,
   output logic line_pullup_en,
   output logic [1:0] chan_a_vsel,
   output logic [1:0] chan_b_vsel,
   output logic chan_a_select,
   output logic chan_b_select,
   output logic inter_card_link,
   output logic deact_a,
   output logic deact_b
);
   localparam int NPIN = 11;

   logic [NPIN-1:0] pins_raw;
   logic [NPIN-1:0] pins_s;
   logic sclk_s;
   logic din_s;
   logic ld_n_s;
   logic det_a_s;
   logic det_b_s;
   logic uv_n_s;
   logic efa_s;
   logic efb_s;
   logic ata_s;
   logic atb_s;
   logic rsta_s;
   logic rstb_s;
   logic rstb_inv;

   // Idle-high pins pass the synchroniser inverted so its cleared state is their idle level;
   // otherwise reset would be followed by a false clock edge, strobe edge or supply fault
   localparam logic [NPIN-1:0] IDLE_HIGH = 11'h521;

   // Every pin is brought onto ref_clk before any logic looks at it
   assign pins_raw = {sclk_pin, din_pin, load_strobe_n, card_detect_input_a,
      card_detect_input_b, supply_low_monitor_n, elec_fault_in_a, elec_fault_in_b,
      atr_timeout_in_a, atr_timeout_in_b, card_reset_a} ^ IDLE_HIGH;

   dcsp_sync #(
      .W(NPIN)
   ) u_sync_pins (
      .ref_clk(ref_clk),
      .rst(rst),
      .async_in(pins_raw),
      .sync_out(pins_s)
   );

   dcsp_sync #(
      .W(1)
   ) u_sync_rstb (
      .ref_clk(ref_clk),
      .rst(rst),
      .async_in(~card_reset_b),
      .sync_out(rstb_inv)
   );

   assign rstb_s = ~rstb_inv;
   assign {sclk_s, din_s, ld_n_s, det_a_s, det_b_s, uv_n_s, efa_s, efb_s, ata_s, atb_s,
      rsta_s} = pins_s ^ IDLE_HIGH;

   // Serial port state
   logic sclk_d_r;
   logic ld_d_r;
   logic [15:0] shift_r;
   logic [15:0] shift_nxt;
   logic [15:0] cmd_r;
   logic [15:0] cmd_nxt;
   logic dout_r;
   logic dout_nxt;
   logic sclk_rise;
   logic ld_fall;
   logic ld_rise;

   // Fault and presence state
   logic [1:0] present_r;
   logic [1:0] present_nxt;
   logic [dcsp_pkg::DEB_CNT_W-1:0] deb_cnt_r [2];
   logic [dcsp_pkg::DEB_CNT_W-1:0] deb_cnt_nxt [2];
   logic [1:0] elec_err_r;
   logic [1:0] elec_err_nxt;
   logic [1:0] atr_err_r;
   logic [1:0] atr_err_nxt;
   logic fault_r;
   logic fault_nxt;
   logic [15:0] status_w;
   logic [1:0] det_raw;
   logic [1:0] vsel_cmd [2];
   logic [1:0] ef_in;
   logic [1:0] at_in;
   logic [1:0] rst_in;

   // Register window state
   logic detect_high_r;
   logic detect_high_nxt;
   logic wr_pend_r;
   logic wr_pend_nxt;
   logic [3:0] wr_addr_r;
   logic [3:0] wr_addr_nxt;
   logic [31:0] hrdata_nxt;
   logic addr_ok;

   assign sclk_rise = sclk_s & ~sclk_d_r;
   assign ld_fall = ~ld_n_s & ld_d_r;
   assign ld_rise = ld_n_s & ~ld_d_r;

   // Index 1 is channel A, index 0 is channel B
   assign det_raw[1] = detect_high_r ? det_a_s : ~det_a_s;
   assign det_raw[0] = detect_high_r ? det_b_s : ~det_b_s;
   assign ef_in = {efa_s, efb_s};
   assign at_in = {ata_s, atb_s};
   assign rst_in = {rsta_s, rstb_s};
   assign vsel_cmd[1] = cmd_r[dcsp_pkg::CMD_A_VSEL_LO +: 2];
   assign vsel_cmd[0] = cmd_r[dcsp_pkg::CMD_B_VSEL_LO +: 2];

   always_comb
   begin
      status_w = dcsp_pkg::STATUS_RESET;
      status_w[dcsp_pkg::ST_A_PRESENT] = present_r[1];
      status_w[dcsp_pkg::ST_B_PRESENT] = present_r[0];
      status_w[dcsp_pkg::ST_A_ELEC] = elec_err_r[1];
      status_w[dcsp_pkg::ST_A_ATR] = atr_err_r[1];
      status_w[dcsp_pkg::ST_B_ELEC] = elec_err_r[0];
      status_w[dcsp_pkg::ST_B_ATR] = atr_err_r[0];
   end

   // Serial shift path; edges found by sampling the host clock on ref_clk
   always_comb
   begin
      shift_nxt = shift_r;
      cmd_nxt = cmd_r;
      if (ld_rise)
      begin
         shift_nxt = status_w;
      end
      else if (sclk_rise)
      begin
         shift_nxt = {shift_r[14:0], din_s};
      end
      if (ld_fall)
      begin
         cmd_nxt = shift_r;
      end
      // Transparent while the strobe is low: output follows live card A presence
      dout_nxt = ld_n_s ? shift_nxt[15] : present_nxt[1];
   end

   // Presence debounce, card faults and the fault line
   always_comb
   begin
      for (int c = 0; c < 2; c++)
      begin
         deb_cnt_nxt[c] = deb_cnt_r[c];
         present_nxt[c] = present_r[c];
         if (!det_raw[c])
         begin
            // Removal is seen at once so a pulled card is shut down fast
            deb_cnt_nxt[c] = '0;
            present_nxt[c] = 1'b0;
         end
         else if (!present_r[c])
         begin
            if (32'(deb_cnt_r[c]) + 32'd1 >= DEBOUNCE_CYCLES)
            begin
               present_nxt[c] = 1'b1;
            end
            else
            begin
               deb_cnt_nxt[c] = deb_cnt_r[c] + 1'b1;
            end
         end
         elec_err_nxt[c] = elec_err_r[c];
         if (vsel_cmd[c] == 2'b00)
         begin
            elec_err_nxt[c] = 1'b0;
         end
         // Set terms follow the clear so a fault in the clearing cycle is kept
         if (ef_in[c])
         begin
            elec_err_nxt[c] = 1'b1;
         end
         if ((vsel_cmd[c] != 2'b00) && !present_r[c])
         begin
            elec_err_nxt[c] = 1'b1;
         end
         if (!uv_n_s)
         begin
            elec_err_nxt[c] = 1'b1;
         end
         atr_err_nxt[c] = atr_err_r[c];
         if (!rst_in[c])
         begin
            atr_err_nxt[c] = 1'b0;
         end
         if (at_in[c])
         begin
            atr_err_nxt[c] = 1'b1;
         end
      end
      fault_nxt = |{elec_err_nxt, atr_err_nxt};
   end

   // Register window: zero wait states, always OKAY
   assign addr_ok = hsel & hready & (htrans == dcsp_pkg::HTRANS_NONSEQ);

   always_comb
   begin
      // Writes above the map are dropped, not aliased onto the low offsets
      wr_pend_nxt = addr_ok & hwrite & (haddr[31:dcsp_pkg::ADDR_W] == '0);
      wr_addr_nxt = haddr[dcsp_pkg::ADDR_W-1:0];
      detect_high_nxt = detect_high_r;
      if (wr_pend_r && (wr_addr_r == dcsp_pkg::REG_CONFIG))
      begin
         detect_high_nxt = hwdata[dcsp_pkg::CFG_DETECT_HIGH];
      end
      hrdata_nxt = hrdata;
      if (addr_ok && !hwrite)
      begin
         hrdata_nxt = 32'h0000_0000;
         if (haddr[31:dcsp_pkg::ADDR_W] == '0)
         begin
            unique case (haddr[dcsp_pkg::ADDR_W-1:0])
               dcsp_pkg::REG_STATUS: hrdata_nxt = {16'h0000, status_w};
               dcsp_pkg::REG_COMMAND: hrdata_nxt = {16'h0000, cmd_r};
               // Forward a write still in its data phase
               dcsp_pkg::REG_CONFIG: hrdata_nxt = {31'h0000_0000, detect_high_nxt};
               default: hrdata_nxt = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         sclk_d_r <= 1'b1;
         ld_d_r <= 1'b1;
         shift_r <= dcsp_pkg::STATUS_RESET;
         cmd_r <= dcsp_pkg::CMD_RESET;
         dout_r <= 1'b0;
         present_r <= 2'b00;
         deb_cnt_r[0] <= '0;
         deb_cnt_r[1] <= '0;
         elec_err_r <= 2'b00;
         atr_err_r <= 2'b00;
         fault_r <= 1'b0;
         detect_high_r <= dcsp_pkg::CONFIG_RESET[dcsp_pkg::CFG_DETECT_HIGH];
         wr_pend_r <= 1'b0;
         wr_addr_r <= 4'h0;
         hrdata <= 32'h0000_0000;
      end
      else
      begin
         sclk_d_r <= sclk_s;
         ld_d_r <= ld_n_s;
         shift_r <= shift_nxt;
         cmd_r <= cmd_nxt;
         dout_r <= dout_nxt;
         present_r <= present_nxt;
         deb_cnt_r[0] <= deb_cnt_nxt[0];
         deb_cnt_r[1] <= deb_cnt_nxt[1];
         elec_err_r <= elec_err_nxt;
         atr_err_r <= atr_err_nxt;
         fault_r <= fault_nxt;
         detect_high_r <= detect_high_nxt;
         wr_pend_r <= wr_pend_nxt;
         wr_addr_r <= wr_addr_nxt;
         hrdata <= hrdata_nxt;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = dcsp_pkg::HRESP_OKAY;
   assign dout_pin = dout_r;

   // Only ever pulls low; the board pull-up gives the high level
   assign fault_n_o = 1'b0;
   assign fault_n_oe = fault_r;

   // Command acts straight from the register loaded on the strobe fall
   assign line_pullup_en = ~cmd_r[dcsp_pkg::CMD_PULLUP_DIS];
   // A channel with an electrical fault is held powered down until software clears it
   assign chan_a_vsel = elec_err_r[1] ? 2'b00 : vsel_cmd[1];
   assign chan_b_vsel = elec_err_r[0] ? 2'b00 : vsel_cmd[0];
   assign deact_a = elec_err_r[1];
   assign deact_b = elec_err_r[0];
   assign chan_a_select = cmd_r[dcsp_pkg::CMD_A_SELECT] & present_r[1];
   assign chan_b_select = cmd_r[dcsp_pkg::CMD_B_SELECT] & present_r[0];
   assign inter_card_link = chan_a_select & chan_b_select;
endmodule : dcsp_top
`default_nettype wire

/* File: dv/dcsp_host_model.sv */
// Host microcontroller model acting as serial master of the port
`timescale 1ns/100ps
`default_nettype none
module dcsp_host_model (
   output logic sclk_pin,
   output logic din_pin,
   output logic load_strobe_n,
   input wire logic dout_pin
);
   initial
   begin
      sclk_pin <= 1'h1;
      din_pin <= 1'h0;
      load_strobe_n <= 1'h1;
   end
   // Data changes at the fall, both ends sample at the rise; clock idles high between frames
   task automatic shift(input logic [15:0] w, output logic [15:0] r);
      for (int i = 15; i >= 0; i--)
      begin
         sclk_pin <= 1'h0;
         din_pin <= w[i];
         #62.5;
         r[i] = dout_pin;
         sclk_pin <= 1'h1;
         #62.5;
      end
      // Line left inverted so a stale bit never reads as valid
      din_pin <= ~w[0];
   endtask : shift
   // Strobe moves only after the whole chain is shifted, and holds the level given while waiting
   task automatic strobe(input logic v);
      load_strobe_n <= v;
      #250;
   endtask : strobe
endmodule : dcsp_host_model
`default_nettype wire

/* File: dv/dcsp_top_sva.sv */
// Concurrent checks on the pins of the dual-card serial control port
`timescale 1ns/100ps
`default_nettype none
module dcsp_top_sva #(
   parameter int unsigned DEBOUNCE_CYCLES = 8
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic load_strobe_n,
   input wire logic dout_pin,
   input wire logic card_detect_input_a,
   input wire logic supply_low_monitor_n,
   input wire logic elec_fault_in_a,
   input wire logic elec_fault_in_b,
   input wire logic fault_n_o,
   input wire logic fault_n_oe,
   input wire logic [1:0] chan_a_vsel,
   input wire logic chan_a_select,
   input wire logic chan_b_select,
   input wire logic inter_card_link,
   input wire logic deact_a,
   input wire logic deact_b
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   property p_odrain;
      fault_n_o == 1'h0;
   endproperty
   a_odrain: assert property (p_odrain) else $error("fault pin driven high");
   property p_elec_raise;
      $rose(elec_fault_in_a) |-> ##[2:9] fault_n_oe;
   endproperty
   a_elec_raise: assert property (p_elec_raise) else $error("fault not raised");
   property p_fault_or;
      (deact_a || deact_b) |-> fault_n_oe;
   endproperty
   a_fault_or: assert property (p_fault_or) else $error("fault output misses flag");
   property p_deact_b;
      $rose(elec_fault_in_b) |-> ##[2:9] deact_b;
   endproperty
   a_deact_b: assert property (p_deact_b) else $error("channel b not deactivated");
   property p_supply_low_monitor;
      $fell(supply_low_monitor_n) |-> ##[2:9] (deact_a && deact_b);
   endproperty
   a_supply_low_monitor: assert property (p_supply_low_monitor) else $error("supply trip ignored");
   property p_link;
      inter_card_link == (chan_a_select && chan_b_select);
   endproperty
   a_link: assert property (p_link) else $error("card link wrong");
   property p_vsel_forced;
      deact_a && $past(deact_a) |-> chan_a_vsel == 2'h0;
   endproperty
   a_vsel_forced: assert property (p_vsel_forced) else $error("faulted channel powered");
   // Pin polarity taken with the detect config bit at zero
   property p_no_card;
      card_detect_input_a [*8] |-> !chan_a_select;
   endproperty
   a_no_card: assert property (p_no_card) else $error("absent card selected");
   property p_live_dout;
      (!load_strobe_n && card_detect_input_a) [*8] |-> !dout_pin;
   endproperty
   a_live_dout: assert property (p_live_dout) else $error("serial out not live");
endmodule : dcsp_top_sva
bind dcsp_top dcsp_top_sva #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) i_sva (.ref_clk(ref_clk),
   .rst(rst), .load_strobe_n(load_strobe_n), .dout_pin(dout_pin),
   .card_detect_input_a(card_detect_input_a), .supply_low_monitor_n(supply_low_monitor_n),
   .elec_fault_in_a(elec_fault_in_a), .elec_fault_in_b(elec_fault_in_b),
   .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe), .chan_a_vsel(chan_a_vsel),
   .chan_a_select(chan_a_select), .chan_b_select(chan_b_select),
   .inter_card_link(inter_card_link), .deact_a(deact_a), .deact_b(deact_b));
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench for the dual-card serial control port
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic ref_clk, rst, hsel, hwrite, hreadyout, hresp, sclk_pin, din_pin, load_strobe_n;
   logic dout_pin, card_detect_input_a, card_detect_input_b, supply_low_monitor_n;
   logic elec_fault_in_a, elec_fault_in_b, atr_timeout_in_a, card_reset_a, fault_n_o;
   logic fault_n_oe, line_pullup_en, chan_a_select, chan_b_select, inter_card_link;
   logic deact_a, deact_b, atr_timeout_in_b, card_reset_b;
   logic [1:0] htrans, chan_a_vsel, chan_b_vsel;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [15:0] r;
   int err_count, cmp_count, cyc;
   dcsp_top #(.DEBOUNCE_CYCLES(8)) i_dcsp_top (.ref_clk, .rst, .hsel, .haddr, .htrans,
      .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
      .sclk_pin, .din_pin, .load_strobe_n, .dout_pin, .card_detect_input_a,
      .card_detect_input_b, .supply_low_monitor_n, .elec_fault_in_a, .elec_fault_in_b,
      .atr_timeout_in_a, .atr_timeout_in_b, .card_reset_a, .card_reset_b,
      .fault_n_o, .fault_n_oe, .line_pullup_en, .chan_a_vsel, .chan_b_vsel,
      .chan_a_select, .chan_b_select, .inter_card_link, .deact_a, .deact_b);
   dcsp_host_model i_host (.sclk_pin, .din_pin, .load_strobe_n, .dout_pin);
   initial
   begin
      ref_clk = 1'h0;
      forever #2 ref_clk = ~ref_clk;
   end
   task automatic final_report;
      if (err_count == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report
   // A hung handshake ends the run here
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         final_report();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         $display("wrong value %s exp %h got %h", nm, e, g);
         err_count++;
      end
   endtask : chk
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'h1;
      haddr <= a;
      hwrite <= w;
      htrans <= dcsp_pkg::HTRANS_NONSEQ;
      do @(posedge ref_clk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hsel <= 1'h0;
      hwdata <= d;
      do @(posedge ref_clk); while (hreadyout !== 1'h1);
      q = hrdata;
   endtask : ahb
   task automatic settle;
      repeat (20) @(posedge ref_clk);
   endtask : settle
   task automatic load(input logic [15:0] w);
      i_host.shift(w, r);
      i_host.strobe(1'h0);
      i_host.strobe(1'h1);
   endtask : load
   task automatic t_bus;
      ahb(1'h0, 32'h8, 32'h0);
      chk("cfg", 32'h0, q);
      chk("hresp", 32'h0, {31'h0, hresp});
      ahb(1'h1, 32'h8, 32'h1);
      ahb(1'h0, 32'h8, 32'h0);
      chk("cfg", 32'h1, q);
      ahb(1'h1, 32'h8, 32'h0);
      ahb(1'h1, 32'h18, 32'hFFFF);
      ahb(1'h0, 32'h8, 32'h0);
      chk("alias", 32'h0, q);
      ahb(1'h0, 32'h18, 32'h0);
      chk("unmapped", 32'h0, q);
   endtask : t_bus
   task automatic t_serial;
      card_detect_input_a <= 1'h0;
      settle();
      i_host.shift(16'hA5C3, r);
      i_host.shift(16'h0508, r);
      chk("chain", 32'hA5C3, {16'h0, r});
      chk("early", 32'h0, {30'h0, chan_a_vsel});
      i_host.strobe(1'h0);
      chk("vsel", 32'h1, {30'h0, chan_a_vsel});
      chk("pullup", 32'h0, {31'h0, line_pullup_en});
      chk("live", 32'h1, {31'h0, dout_pin});
      card_detect_input_a <= 1'h1;
      settle();
      chk("live", 32'h0, {31'h0, dout_pin});
      chk("sel", 32'h0, {31'h0, chan_a_select});
      chk("deact", 32'h1, {31'h0, deact_a});
      i_host.strobe(1'h1);
      i_host.shift(16'h0, r);
      chk("status", 32'h1000, {16'h0, r});
      i_host.strobe(1'h0);
      chk("clear", 32'h0, {31'h0, fault_n_oe});
      i_host.strobe(1'h1);
      card_detect_input_a <= 1'h0;
   endtask : t_serial
   task automatic t_fault;
      elec_fault_in_a <= 1'h1;
      elec_fault_in_b <= 1'h1;
      settle();
      chk("oe", 32'h1, {31'h0, fault_n_oe});
      chk("deact", 32'h3, {30'h0, deact_a, deact_b});
      elec_fault_in_a <= 1'h0;
      elec_fault_in_b <= 1'h0;
      settle();
      chk("oe", 32'h0, {31'h0, fault_n_oe});
      atr_timeout_in_a <= 1'h1;
      atr_timeout_in_b <= 1'h1;
      settle();
      atr_timeout_in_a <= 1'h0;
      atr_timeout_in_b <= 1'h0;
      ahb(1'h0, 32'h0, 32'h0);
      chk("status", 32'hA020, q);
      chk("oe", 32'h1, {31'h0, fault_n_oe});
      card_reset_a <= 1'h0;
      settle();
      chk("oe", 32'h1, {31'h0, fault_n_oe});
      card_reset_b <= 1'h0;
      settle();
      chk("oe", 32'h0, {31'h0, fault_n_oe});
      card_reset_a <= 1'h1;
      card_reset_b <= 1'h1;
      supply_low_monitor_n <= 1'h0;
      settle();
      chk("uv", 32'h3, {30'h0, deact_a, deact_b});
      supply_low_monitor_n <= 1'h1;
      settle();
   endtask : t_fault
   task automatic t_link;
      logic [15:0] w [4] = '{16'h0005, 16'h0001, 16'h0501, 16'h0505};
      card_detect_input_b <= 1'h0;
      settle();
      foreach (w[i])
      begin
         load(w[i]);
         chk("link", {31'h0, i == 3}, {31'h0, inter_card_link});
         chk("bsel", {31'h0, w[i][dcsp_pkg::CMD_B_SELECT]}, {31'h0, chan_b_select});
         chk("bvsel", {30'h0, w[i][1:0]}, {30'h0, chan_b_vsel});
      end
      load(16'h0);
   endtask : t_link
   initial
   begin
      rst <= 1'h1;
      hsel <= 1'h0;
      haddr <= 32'h0;
      htrans <= 2'h0;
      hwrite <= 1'h0;
      hwdata <= 32'h0;
      card_detect_input_a <= 1'h1;
      card_detect_input_b <= 1'h1;
      supply_low_monitor_n <= 1'h1;
      elec_fault_in_a <= 1'h0;
      elec_fault_in_b <= 1'h0;
      atr_timeout_in_a <= 1'h0;
      atr_timeout_in_b <= 1'h0;
      card_reset_a <= 1'h1;
      card_reset_b <= 1'h1;
      repeat (10) @(posedge ref_clk);
      rst <= 1'h0;
      repeat (3) @(posedge ref_clk);
      t_bus();
      t_serial();
      t_fault();
      t_link();
      final_report();
   end
endmodule : tb
`default_nettype wire
